// ==== shared/fe_pkg.sv ====
// constants, types and code-group lookup for the fast ethernet receive pcs path
//
// Behaviour
// - transmit stage splits serial nrzi into two drive streams with alternating one events
// - at 100 Mb/s only three-level output exists; there is no binary option
// - signal detect stays low for short link pulses and fast link pulses
// - three-level line symbols become a binary nrzi stream before further decoding
// - nrzi stream becomes nrz and feeds the descrambler
// - serial bits are gathered into 5-bit groups for the pcs decoder
// - descrambler builds the remote key and xors it with each scrambled bit
// - twelve consecutive idle groups (five ones each) bring descrambler sync
// - on sync a hold timer counts down 722 us
// - 58 idle bit times within the period restart the hold timer
// - hold timer expiry drops sync, resets the descrambler and restarts acquisition
// - alignment takes descrambler output, or nrz bits directly when bypassed
// - alignment locks the group boundary on the pair 11000 10001
// - start pair after idle is handed to the mac as nibbles 0101 0101
// - after the start pair every group is looked up into a nibble
// - conversion stops on the end pair or on two idle groups
// - link goes up only after signal detect held 395 us
// - transmit and receive pcs stay disabled until the link is up
// - idle, start and end groups inside data decode as invalid with error
// - data groups use the standard sixteen-entry 4b/5b mapping
// - key comes from a closed-loop 11-bit lfsr matching the transmit scrambler
package fe_pkg;
  localparam int CLK_MHZ = 50;
  localparam int HOLD_US = 722;
  localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
  localparam int LINK_US = 395;
  localparam int LINK_CYC = LINK_US * CLK_MHZ;
  localparam int SD_QUAL_NS = 200;
  localparam int SD_QUAL_CYC = (SD_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int GRP_BITS = 5;
  localparam int SYNC_IDLES = 12;
  localparam int SYNC_ONES = SYNC_IDLES * GRP_BITS;
  localparam int IDLE_BITS = 58;
  localparam int LFSR_TAP_A = 10;
  localparam int LFSR_TAP_B = 8;
  localparam logic [10:0] LFSR_RST = 11'h000;
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_ERR = 4'hE;
  localparam int FIFO_WIDTH = 5;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    FE_DEC_IDLE = 3'b001,
    FE_DEC_PKT = 3'b010,
    FE_DEC_TERM = 3'b100
  } fe_dec_state_t;

  // returns {data_valid, nibble}; control and invalid groups give valid low
  function automatic logic [4:0] fe_dec5b(input logic [4:0] cg);
    case (cg)
      5'h1E: fe_dec5b = 5'h10;
      5'h09: fe_dec5b = 5'h11;
      5'h14: fe_dec5b = 5'h12;
      5'h15: fe_dec5b = 5'h13;
      5'h0A: fe_dec5b = 5'h14;
      5'h0B: fe_dec5b = 5'h15;
      5'h0E: fe_dec5b = 5'h16;
      5'h0F: fe_dec5b = 5'h17;
      5'h12: fe_dec5b = 5'h18;
      5'h13: fe_dec5b = 5'h19;
      5'h16: fe_dec5b = 5'h1A;
      5'h17: fe_dec5b = 5'h1B;
      5'h1A: fe_dec5b = 5'h1C;
      5'h1B: fe_dec5b = 5'h1D;
      5'h1C: fe_dec5b = 5'h1E;
      5'h1D: fe_dec5b = 5'h1F;
      default: fe_dec5b = {1'b0, NIB_ERR};
    endcase
  endfunction
endpackage

// ==== design/fe_fifo.sv ====
// synchronous valid/ready fifo with flip-flop storage
`timescale 1ns/1ns
module fe_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic do_wr;
  logic do_rd;

  // full and empty come straight from the occupancy count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // storage is written only, never reset, to keep it plain flops
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_r[wr_r] <= in_data;
    end
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_wr) begin
        wr_r <= wr_r + 1'b1;
      end
      if (do_rd) begin
        rd_r <= rd_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // fe_fifo

// ==== design/fe_rx_pcs.sv ====
// 100 Mb/s line decode, descrambler, alignment, 4b/5b decode and link monitor
`timescale 1ns/1ns
module fe_rx_pcs #(
  parameter int HOLD_CYC = fe_pkg::HOLD_CYC,
  parameter int LINK_CYC = fe_pkg::LINK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // equalised line symbol: 00 zero, 01 plus, 11 minus
  input wire logic [1:0] rx_sym,
  input wire logic sd_energy,
  // configuration
  input wire logic descr_bypass,
  // transmit line stage
  input wire logic tx_nrzi,
  output logic tx_drv_p,
  output logic tx_drv_n,
  // nibble stream to the mac
  output logic [3:0] mii_rxd,
  output logic mii_rx_er,
  output logic mii_rx_valid,
  input wire logic mii_rx_ready,
  // status
  output logic sig_det,
  output logic link_up,
  output logic descr_locked,
  output logic rx_overflow
);
  logic sig_det_r;
  logic [7:0] sd_run_r;
  logic link_up_r;
  logic [15:0] link_cnt_r;
  logic [1:0] sym_prev_r;
  logic nrzi_r;
  logic nrzi_prev_r;
  logic nrz;
  logic [10:0] lfsr_r;
  logic key;
  logic ud;
  logic synced_r;
  logic [5:0] ones_r;
  logic [15:0] hold_r;
  logic sbit;
  logic data_ok;
  logic [14:0] sh_r;
  logic [2:0] cnt_r;
  logic grp_stb;
  logic jk_hit;
  logic lock_go;
  fe_pkg::fe_dec_state_t st_r;
  logic pre2_r;
  logic idle1_r;
  logic [4:0] dec;
  logic push_v;
  logic [4:0] push_d;
  logic push_rdy;
  logic ovf_r;
  logic ph_r;
  logic drv_p_r;
  logic drv_n_r;
  logic [4:0] fifo_q;

  // signal detect needs energy longer than any link pulse burst
  always_ff @(posedge clk) begin
    if (srst || !sd_energy) begin
      sd_run_r <= '0;
      sig_det_r <= 1'b0;
    end else if (sd_run_r == 8'(fe_pkg::SD_QUAL_CYC - 1)) begin
      sig_det_r <= 1'b1;
    end else begin
      sd_run_r <= sd_run_r + 8'h01;
    end
  end

  // link monitor: qualification restarts on any drop of signal detect
  always_ff @(posedge clk) begin
    if (srst || !sig_det_r) begin
      link_cnt_r <= '0;
      link_up_r <= 1'b0;
    end else if (link_cnt_r == 16'(LINK_CYC - 1)) begin
      link_up_r <= 1'b1;
    end else begin
      link_cnt_r <= link_cnt_r + 16'h0001;
    end
  end

  // three-level to nrzi, then nrzi to nrz; a level change toggles nrzi
  always_ff @(posedge clk) begin
    if (srst) begin
      sym_prev_r <= 2'h0;
      nrzi_r <= 1'b0;
      nrzi_prev_r <= 1'b0;
    end else begin
      sym_prev_r <= rx_sym;
      nrzi_r <= nrzi_r ^ (rx_sym != sym_prev_r);
      nrzi_prev_r <= nrzi_r;
    end
  end
  assign nrz = nrzi_r ^ nrzi_prev_r;

  // descrambler key from the 11-bit register, xor recovers the plain bit
  assign key = lfsr_r[fe_pkg::LFSR_TAP_A] ^ lfsr_r[fe_pkg::LFSR_TAP_B];
  assign ud = nrz ^ key;

  // acquisition loads the register from the line assuming idle, then closes the loop;
  // the whole descrambler sits in reset while the link is down
  always_ff @(posedge clk) begin
    if (srst || !link_up_r) begin
      lfsr_r <= fe_pkg::LFSR_RST;
      synced_r <= 1'b0;
      ones_r <= '0;
      hold_r <= '0;
    end else if (synced_r && hold_r == 16'h0000) begin
      lfsr_r <= fe_pkg::LFSR_RST;
      synced_r <= 1'b0;
      ones_r <= '0;
    end else begin
      lfsr_r <= synced_r ? {lfsr_r[9:0], key} : {lfsr_r[9:0], ~nrz};
      ones_r <= !ud ? 6'h00 : (ones_r == 6'h3F) ? ones_r : ones_r + 6'h01;
      if (!synced_r) begin
        if (ud && ones_r == 6'(fe_pkg::SYNC_ONES - 1)) begin
          synced_r <= 1'b1;
          hold_r <= 16'(HOLD_CYC);
        end
      end else if (ud && ones_r == 6'(fe_pkg::IDLE_BITS - 1)) begin
        hold_r <= 16'(HOLD_CYC);
      end else begin
        hold_r <= hold_r - 16'h0001;
      end
    end
  end

  // alignment source is the descrambler or, when bypassed, the raw nrz bit
  assign sbit = descr_bypass ? nrz : ud;
  assign data_ok = link_up_r && (descr_bypass || synced_r);
  assign jk_hit = (sh_r[9:0] == {fe_pkg::CG_J, fe_pkg::CG_K});
  assign lock_go = (st_r == fe_pkg::FE_DEC_IDLE) && data_ok && jk_hit
    && (sh_r[14:10] == fe_pkg::CG_IDLE);
  assign grp_stb = (st_r != fe_pkg::FE_DEC_IDLE) && (cnt_r == 3'h4);

  // serial to parallel: free-running 5-bit framing, re-phased on the start pair
  always_ff @(posedge clk) begin
    if (srst) begin
      sh_r <= '0;
      cnt_r <= 3'h0;
    end else begin
      sh_r <= {sh_r[13:0], sbit};
      if (lock_go || cnt_r == 3'h4) begin
        cnt_r <= 3'h0;
      end else begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  assign dec = fe_pkg::fe_dec5b(sh_r[4:0]);

  // packet decode state; the boundary stays locked until the packet ends
  always_ff @(posedge clk) begin
    if (srst || !data_ok) begin
      st_r <= fe_pkg::FE_DEC_IDLE;
      idle1_r <= 1'b0;
    end else begin
      case (st_r)
        fe_pkg::FE_DEC_IDLE: begin
          idle1_r <= 1'b0;
          if (lock_go) begin
            st_r <= fe_pkg::FE_DEC_PKT;
          end
        end
        fe_pkg::FE_DEC_PKT: begin
          if (grp_stb) begin
            idle1_r <= (sh_r[4:0] == fe_pkg::CG_IDLE);
            if (sh_r[4:0] == fe_pkg::CG_IDLE && idle1_r) begin
              st_r <= fe_pkg::FE_DEC_IDLE;
            end else if (sh_r[4:0] == fe_pkg::CG_T) begin
              st_r <= fe_pkg::FE_DEC_TERM;
            end
          end
        end
        fe_pkg::FE_DEC_TERM: begin
          if (grp_stb) begin
            idle1_r <= 1'b0;
            st_r <= (sh_r[4:0] == fe_pkg::CG_R) ? fe_pkg::FE_DEC_IDLE : fe_pkg::FE_DEC_PKT;
          end
        end
        default: st_r <= fe_pkg::FE_DEC_IDLE;
      endcase
    end
  end

  // second preamble nibble follows the first by one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pre2_r <= 1'b0;
    end else begin
      pre2_r <= lock_go;
    end
  end

  // nibble push: preamble pair, data lookup, or error for stray control groups;
  // a lone T that is not followed by R is reported as one error nibble
  always_comb begin
    push_v = 1'b0;
    push_d = {1'b0, fe_pkg::NIB_PRE};
    if (lock_go || pre2_r) begin
      push_v = 1'b1;
    end else if (grp_stb && st_r == fe_pkg::FE_DEC_PKT) begin
      if (dec[4]) begin
        push_v = 1'b1;
        push_d = {1'b0, dec[3:0]};
      end else if (sh_r[4:0] != fe_pkg::CG_T && !(idle1_r && sh_r[4:0] == fe_pkg::CG_IDLE)) begin
        push_v = 1'b1;
        push_d = {1'b1, fe_pkg::NIB_ERR};
      end
    end else if (grp_stb && st_r == fe_pkg::FE_DEC_TERM && sh_r[4:0] != fe_pkg::CG_R) begin
      push_v = 1'b1;
      push_d = {1'b1, fe_pkg::NIB_ERR};
    end
  end

  // a line stream cannot wait, so a full fifo drops the nibble and is latched
  always_ff @(posedge clk) begin
    if (srst) begin
      ovf_r <= 1'b0;
    end else if (push_v && !push_rdy) begin
      ovf_r <= 1'b1;
    end
  end

  fe_fifo #(
    .WIDTH(fe_pkg::FIFO_WIDTH),
    .DEPTH(fe_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(push_v),
    .in_ready(push_rdy),
    .in_data(push_d),
    .out_valid(mii_rx_valid),
    .out_ready(mii_rx_ready),
    .out_data(fifo_q)
  );

  // transmit line stage: ones alternate between the two driver phases,
  // only the three-level form exists and it stays quiet while the link is down
  always_ff @(posedge clk) begin
    if (srst || !link_up_r) begin
      ph_r <= 1'b0;
      drv_p_r <= 1'b0;
      drv_n_r <= 1'b0;
    end else begin
      drv_p_r <= tx_nrzi && !ph_r;
      drv_n_r <= tx_nrzi && ph_r;
      if (tx_nrzi) begin
        ph_r <= ~ph_r;
      end
    end
  end

  assign tx_drv_p = drv_p_r;
  assign tx_drv_n = drv_n_r;
  assign mii_rxd = fifo_q[3:0];
  assign mii_rx_er = fifo_q[4];
  assign sig_det = sig_det_r;
  assign link_up = link_up_r;
  assign descr_locked = synced_r;
  assign rx_overflow = ovf_r;

  // checking helpers
  logic last_p_r;
  always_ff @(posedge clk) begin
    if (srst || !link_up_r) begin
      last_p_r <= 1'b0;
    end else if (drv_p_r || drv_n_r) begin
      last_p_r <= drv_p_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_sd_pulse_reject: assert property ($rose(sig_det_r) |-> $past(sd_energy, 1)
    && $past(sd_energy, 5) && $past(sd_energy, 9))
    else $error("signal detect rose on a short burst");
  a_sd_drop: assert property (!sd_energy |=> !sig_det_r)
    else $error("signal detect held without energy");
  a_nrzi_edge: assert property (##2 (rx_sym != $past(rx_sym)) |=> nrz)
    else $error("symbol change not decoded as one");
  a_nrz_steady: assert property (##2 (rx_sym == $past(rx_sym)) |=> !nrz)
    else $error("steady symbol decoded as one");
  a_key_loop: assert property (synced_r && $past(synced_r) && $past(hold_r) != 16'h0000
    |-> lfsr_r[0] == $past(key))
    else $error("descrambler loop not closed");
  a_sync_entry: assert property ($rose(synced_r) |-> $past(ones_r) == 6'(fe_pkg::SYNC_ONES - 1)
    && $past(ud) && hold_r == 16'(HOLD_CYC))
    else $error("sync entered without twelve idles");
  a_hold_reload: assert property (synced_r && hold_r != 16'h0000 && ud
    && ones_r == 6'(fe_pkg::IDLE_BITS - 1) |=> hold_r == 16'(HOLD_CYC))
    else $error("hold timer not restarted by idle");
  a_hold_expire: assert property (synced_r && hold_r == 16'h0000 && link_up_r
    |=> !synced_r && lfsr_r == fe_pkg::LFSR_RST && ones_r == 6'h00)
    else $error("sync kept after hold expiry");
  a_link_qual: assert property ($rose(link_up_r) |-> sig_det_r
    && link_cnt_r == 16'(LINK_CYC - 1))
    else $error("link up before qualification");
  a_pcs_gate: assert property (!link_up_r |=> !drv_p_r && !drv_n_r && !synced_r)
    else $error("pcs active with link down");
  a_tx_alternate: assert property ((drv_p_r |-> !last_p_r) and (drv_n_r |-> last_p_r))
    else $error("drive phases did not alternate");
  a_jk_preamble: assert property (lock_go |-> push_v && push_d == {1'b0, fe_pkg::NIB_PRE}
    ##1 push_v && push_d == {1'b0, fe_pkg::NIB_PRE})
    else $error("start pair not replaced by preamble");
  a_two_idle_end: assert property (grp_stb && st_r == fe_pkg::FE_DEC_PKT && idle1_r
    && sh_r[4:0] == fe_pkg::CG_IDLE && data_ok |=> st_r == fe_pkg::FE_DEC_IDLE)
    else $error("two idles did not end the packet");

  c_sync: cover property ($rose(synced_r));
  c_link: cover property ($rose(link_up_r));
  c_start: cover property (lock_go);
  c_end_pair: cover property (grp_stb && st_r == fe_pkg::FE_DEC_TERM
    && sh_r[4:0] == fe_pkg::CG_R);
endmodule // fe_rx_pcs

// ==== verification/fe_mac_model.sv ====
// mii receive side of the mac: collects nibbles, can stall or throttle
`timescale 1ns/1ns
module fe_mac_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // nibble stream from the phy
  input wire logic [3:0] mii_rxd,
  input wire logic mii_rx_er,
  input wire logic mii_rx_valid,
  output logic mii_rx_ready,
  // pacing set by the bench
  input wire logic stall,
  input wire logic slow
);
  logic [4:0] got_q[$];
  logic [1:0] pace_r = 2'h0;

  // ready moves off the sampling edge; slow mode takes one nibble in four
  initial mii_rx_ready = 1'b0;
  always @(negedge clk) begin
    pace_r <= pace_r + 2'h1;
    mii_rx_ready <= !srst && !stall && (!slow || pace_r == 2'h0);
  end

  // a nibble is taken on the edge where valid and ready meet
  always @(posedge clk) begin
    if (mii_rx_valid === 1'b1 && mii_rx_ready === 1'b1) begin
      got_q.push_back({mii_rx_er, mii_rxd});
    end
  end
endmodule // fe_mac_model

// ==== verification/fast_ethernet_rx_pcs_path_test.sv ====
// self-checking bench for the 100 Mb/s receive pcs path
`timescale 1ns/1ns
module fast_ethernet_rx_pcs_path_test;
  localparam int LINK = 20;
  logic clk, srst, sd_energy, descr_bypass, tx_nrzi, stall, slow;
  logic [1:0] rx_sym;
  logic tx_drv_p, tx_drv_n, mii_rx_er, mii_rx_valid, mii_rx_ready;
  logic [3:0] mii_rxd;
  logic sig_det, link_up, descr_locked, rx_overflow, ph;
  int errors, total_checks, cycles, n, t_sd;
  logic [31:0] rnd;
  logic [10:0] scr;
  logic [1:0] mlt;
  logic [4:0] exp_q[$];
  logic [4:0] enc[16];

  fe_rx_pcs #(.HOLD_CYC(200), .LINK_CYC(LINK)) fe_rx_pcs_i (.clk(clk), .srst(srst),
    .rx_sym(rx_sym), .sd_energy(sd_energy), .descr_bypass(descr_bypass), .tx_nrzi(tx_nrzi),
    .tx_drv_p(tx_drv_p), .tx_drv_n(tx_drv_n), .mii_rxd(mii_rxd), .mii_rx_er(mii_rx_er),
    .mii_rx_valid(mii_rx_valid), .mii_rx_ready(mii_rx_ready), .sig_det(sig_det),
    .link_up(link_up), .descr_locked(descr_locked), .rx_overflow(rx_overflow));
  fe_mac_model fe_mac_model_i (.clk(clk), .srst(srst), .mii_rxd(mii_rxd),
    .mii_rx_er(mii_rx_er), .mii_rx_valid(mii_rx_valid), .mii_rx_ready(mii_rx_ready),
    .stall(stall), .slow(slow));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // hang guard: the whole run needs a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      $display("unexpected timeout after %0d cycles", cycles);
      final_report();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask

  // scramble with x^11+x^9+1 unless bypassed, then mlt-3: a one steps 0,+,0,-
  task automatic send_bit(input logic b);
    logic key, sb;
    key = scr[10] ^ scr[8];
    sb = b;
    if (!descr_bypass) begin
      scr = {scr[9:0], key};
      sb = b ^ key;
    end
    mlt = mlt + {1'b0, sb};
    rx_sym = (mlt[0] == 1'b0) ? 2'h0 : (mlt[1] ? 2'h3 : 2'h1);
    @(negedge clk);
  endtask

  // code-group msb goes out first
  task automatic send_grp(input logic [4:0] g);
    for (int i = 4; i >= 0; i--) send_bit(g[i]);
  endtask

  // idle, start pair, data (a stray end group at index stray), end pair, idle
  task automatic pkt(input int len, input int stray, input bit seq);
    logic [3:0] d;
    repeat (4) send_grp(5'h1F);
    send_grp(5'h18);
    send_grp(5'h11);
    exp_q.push_back(5'h05);
    exp_q.push_back(5'h05);
    for (int i = 0; i < len; i++) begin
      rnd = lfsr(rnd);
      d = seq ? 4'(i) : rnd[3:0];
      if (i == stray) begin
        send_grp(5'h07);
        exp_q.push_back(5'h1E);
      end else begin
        send_grp(enc[d]);
        exp_q.push_back({1'b0, d});
      end
    end
    send_grp(5'h0D);
    send_grp(5'h07);
    repeat (4) send_grp(5'h1F);
  endtask

  // wait for the mac to hold every expected nibble, then compare in order;
  // the line never stops, so idle keeps flowing and feeds the hold timer meanwhile
  task automatic check_rx(input string name);
    int k;
    k = 0;
    while (fe_mac_model_i.got_q.size() < exp_q.size() && k < 600) begin
      send_bit(1'b1);
      k++;
    end
    repeat (60) send_bit(1'b1);
    chk("nibble count", 8'(exp_q.size()), 8'(fe_mac_model_i.got_q.size()));
    while (exp_q.size() > 0 && fe_mac_model_i.got_q.size() > 0) begin
      chk("nibble", {3'h0, exp_q.pop_front()}, {3'h0, fe_mac_model_i.got_q.pop_front()});
    end
    exp_q.delete();
    fe_mac_model_i.got_q.delete();
    $display("%s done", name);
  endtask

  task automatic lock_wait();
    n = 0;
    while (descr_locked !== 1'b1 && n < 400) begin
      send_bit(1'b1);
      n++;
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    sd_energy = 1'b0;
    descr_bypass = 1'b0;
    tx_nrzi = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    rx_sym = 2'h0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    t_sd = 0;
    rnd = 32'hE7792A51;
    scr = 11'h5A3;
    mlt = 2'h0;
    enc = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    repeat (8) @(negedge clk);
    srst = 1'b0;
    chk("reset outputs", 8'h00, {2'h0, tx_drv_p, tx_drv_n, sig_det, link_up, descr_locked,
        rx_overflow});

    // 5-cycle bursts look like 100 ns link pulses; transmit held off meanwhile
    tx_nrzi = 1'b1;
    repeat (3) begin
      sd_energy = 1'b1;
      repeat (5) @(negedge clk);
      chk("sig_det on pulse", 8'h00, {7'h0, sig_det});
      chk("tx drive before link", 8'h00, {6'h0, tx_drv_p, tx_drv_n});
      sd_energy = 1'b0;
      repeat (20) @(negedge clk);
    end
    tx_nrzi = 1'b0;
    sd_energy = 1'b1;
    n = 0;
    while (link_up !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
      if (sig_det === 1'b1 && t_sd == 0) t_sd = n;
    end
    chk("sig_det delay", 8'h01, {7'h0, t_sd >= 9 && t_sd <= 11});
    chk("link delay", 8'h01, {7'h0, n - t_sd >= LINK - 1 && n - t_sd <= LINK + 1});
    $display("link test done");

    // ones alternate between the two drive phases, first one on p
    ph = 1'b0;
    repeat (64) begin
      rnd = lfsr(rnd);
      tx_nrzi = rnd[0];
      @(negedge clk);
      chk("tx drive", {6'h0, tx_nrzi & ~ph, tx_nrzi & ph}, {6'h0, tx_drv_p, tx_drv_n});
      ph = ph ^ tx_nrzi;
    end
    tx_nrzi = 1'b0;
    $display("tx test done");

    // scrambled idle brings lock after twelve idle groups
    lock_wait();
    chk("idle bits to lock", 8'h01, {7'h0, n >= 60 && n <= 90});
    pkt(16, -1, 1'b1);
    check_rx("all data codes");
    slow = 1'b1;
    pkt(6, 2, 1'b0);
    check_rx("stray control");
    slow = 1'b0;

    // idle runs of 100 bits every 160 keep the 200-cycle hold timer fed
    repeat (3) begin
      repeat (20) send_bit(1'b1);
      repeat (80) send_bit(1'b1);
      repeat (12) send_grp(enc[0]);
    end
    chk("lock held", 8'h01, {7'h0, descr_locked});
    repeat (10) send_grp(enc[0]);
    chk("lock in period", 8'h01, {7'h0, descr_locked});
    repeat (20) send_grp(enc[0]);
    chk("lock dropped", 8'h00, {7'h0, descr_locked});
    lock_wait();
    chk("relock", 8'h01, {7'h0, n >= 40 && n <= 90});
    $display("hold test done");

    // bypass: unscrambled groups go straight to alignment
    descr_bypass = 1'b1;
    pkt(10, -1, 1'b0);
    check_rx("bypass");

    // stalled mac: fifo keeps sixteen nibbles and flags the rest as dropped
    stall = 1'b1;
    pkt(24, -1, 1'b0);
    while (exp_q.size() > 16) void'(exp_q.pop_back());
    chk("overflow flag", 8'h01, {7'h0, rx_overflow});
    stall = 1'b0;
    check_rx("overflow");
    chk("fifo empty", 8'h00, {7'h0, mii_rx_valid});
    final_report();
  end
endmodule // fast_ethernet_rx_pcs_path_test
